/* inband_dynamic_signalling_inserter.sv */
// Type A in-band signalling block builder with Wishbone register slave
//
// Chosen here: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
// Operation
// - Insert only in padding, second input mode
// - Type B would follow type A; none emitted
// - Block carries change counter and dynamics
// - Enable flag zero suppresses insertion unless both values one
// - Interval and frames both one forces insertion
// - Next-frame parameters sent on first frame
// - Zero other count gives own data only
// - One entry per signalled other pipe
// - Counter advances only on affecting changes
// - Common part: type, counter, reserved
// - Own loop entries then block count
// - Other count then per-pipe entries
// - Trailing field after loops, zero bits here
// - Other count only when both values one
// - Padding type 00 marks type A
module inband_dynamic_signalling_inserter #(
  parameter int OWN_MAX = 8,
  parameter int OTHER_MAX = 16,
  parameter int FIFO_DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic il_first_i,
  output logic [7:0] pad_data_o,
  output logic pad_last_o,
  output logic pad_valid_o,
  input wire logic pad_ready_i
);
  localparam int MEM_DEPTH = 32;
  localparam int MEM_AW = 5;
  localparam int CW = inband_pkg::CHUNK_W;
  // Merge a write word into a register under byte enables
  function automatic logic [31:0] merge(input logic [31:0] old_v,
    input logic [31:0] new_v, input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return r;
  endfunction : merge
  // Expand byte enables into a bit mask
  function automatic logic [31:0] sel_mask(input logic [3:0] sel);
    return merge(32'h0000_0000, 32'hffff_ffff, sel);
  endfunction : sel_mask
  // Register file
  logic [31:0] ctrl, next_ctrl; // Mode, enable flag, interval values
  logic [31:0] counts, next_counts; // Other count and own block count
  logic [7:0] chg_cnt, next_chg_cnt; // pipe_config_change_count
  logic overrun, next_overrun; // Trigger hit a busy builder, sticky
  logic [7:0] sent_cnt, next_sent_cnt; // Blocks completed
  logic [31:0] next_dat; // Read data
  logic next_ack; // Bus acknowledge
  // Serializer
  inband_pkg::ser_state_t state, next_state; // Sequencer state
  inband_pkg::ser_state_t ret, next_ret; // State after the shift
  logic [CW-1:0] sh, next_sh; // Left-aligned chunk being sent
  logic [6:0] cnt, next_cnt; // Bits left in chunk
  logic [MEM_AW-1:0] idx, next_idx; // Loop index j or i
  logic [15:0] bits_left, next_bits_left; // Bits left in block
  logic [7:0] acc, next_acc; // Byte being gathered
  logic [3:0] nbits, next_nbits; // Bits in acc
  logic pend, next_pend; // Byte waiting for the FIFO
  logic [8:0] pend_data, next_pend_data; // {last, byte}
  // Derived control
  logic [7:0] pi_raw, ij_raw; // Frames per interleaving frame, interval
  logic mandatory; // Both values equal one
  logic insert; // Block will be built on a trigger
  logic [7:0] pi_eff; // Clamped own loop length
  logic [7:0] ocnt_eff; // Other count actually sent
  logic busy; // Builder or byte in flight
  logic req; // New bus request
  logic [3:0] nb_inc; // Bits after this shift
  logic [7:0] acc_inc; // Byte after this shift
  // Memory ports
  logic mem_we; // Window write
  logic [CW-1:0] mem_mask; // Half-word byte mask
  logic [MEM_AW-1:0] mem_rd_addr; // Entry being fetched
  logic [CW-1:0] mem_rd_data; // Fetched entry
  byte_stream_if #(.W(9)) push_s ();
  // Derived control values
  always_comb begin
    pi_raw = ctrl[inband_pkg::CTRL_PI_LSB +: 8];
    ij_raw = ctrl[inband_pkg::CTRL_IJ_LSB +: 8];
    mandatory = (pi_raw == 8'h01) && (ij_raw == 8'h01);
    insert = ctrl[inband_pkg::CTRL_MODE_B_BIT] &&
             (ctrl[inband_pkg::CTRL_FLAG_BIT] || mandatory);
    // Own loop length clamped, zero counts as one
    pi_eff = (pi_raw == 8'h00) ? 8'h01 : pi_raw;
    pi_eff = (pi_raw > 8'(OWN_MAX)) ? 8'(OWN_MAX) : pi_eff;
    // Other count clamped to OTHER_MAX
    ocnt_eff = counts[inband_pkg::COUNTS_OCNT_LSB +: 8];
    ocnt_eff = (ocnt_eff > 8'(OTHER_MAX)) ? 8'(OTHER_MAX) : ocnt_eff;
    ocnt_eff = mandatory ? ocnt_eff : 8'h00;
    busy = (state != inband_pkg::ST_IDLE) || pend;
    req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  end
  // Bus decode and register updates
  always_comb begin
    next_ctrl = ctrl;
    next_counts = counts;
    next_chg_cnt = chg_cnt;
    next_overrun = overrun;
    next_sent_cnt = sent_cnt;
    next_dat = wb_dat_o;
    next_ack = req;
    mem_we = 1'b0;
    mem_mask = '0;
    if (req && wb_we_i) begin
      if (wb_adr_i[11:8] == inband_pkg::ADDR_MEM_BASE[11:8]) begin
        // Entry window: low word at +0, high word at +4
        mem_we = 1'b1;
        mem_mask = wb_adr_i[2] ? {sel_mask(wb_sel_i), 32'h0000_0000}
                               : {32'h0000_0000, sel_mask(wb_sel_i)};
      end else if (wb_adr_i == inband_pkg::ADDR_CTRL) begin
        next_ctrl = merge(ctrl, wb_dat_i, wb_sel_i);
      end else if (wb_adr_i == inband_pkg::ADDR_COUNTS) begin
        next_counts = merge(counts, wb_dat_i, wb_sel_i);
      end else if (wb_adr_i == inband_pkg::ADDR_CHANGE) begin
        if (wb_sel_i[0] && wb_dat_i[inband_pkg::CHANGE_ANNOUNCE_BIT] &&
            wb_dat_i[inband_pkg::CHANGE_AFFECTS_BIT]) begin
          next_chg_cnt = chg_cnt + 8'h01;
        end
      end else if (wb_adr_i == inband_pkg::ADDR_STATUS) begin
        // Write one clears the overrun flag
        if (wb_sel_i[0] && wb_dat_i[inband_pkg::STATUS_OVERRUN_BIT]) begin
          next_overrun = 1'b0;
        end
      end
    end else if (req) begin
      // Reads; entry window and unmapped offsets read zero
      unique case (wb_adr_i)
        inband_pkg::ADDR_CTRL: next_dat = ctrl;
        inband_pkg::ADDR_COUNTS: next_dat = counts;
        inband_pkg::ADDR_CHANGE: next_dat = {24'h00_0000, chg_cnt};
        inband_pkg::ADDR_STATUS: begin
          next_dat = 32'h0000_0000;
          next_dat[inband_pkg::STATUS_BUSY_BIT] = busy;
          next_dat[inband_pkg::STATUS_OVERRUN_BIT] = overrun;
          next_dat[inband_pkg::STATUS_SENT_LSB +: 8] = sent_cnt;
        end
        default: next_dat = 32'h0000_0000;
      endcase
    end
    // Set wins over a clear in the same cycle
    if (il_first_i && insert && busy) begin
      next_overrun = 1'b1;
    end
    if (pend && push_s.ready && pend_data[8]) begin
      next_sent_cnt = sent_cnt + 8'h01;
    end
  end
  // Register file flops
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= inband_pkg::CTRL_RESET;
      counts <= inband_pkg::COUNTS_RESET;
      chg_cnt <= 8'h00;
      overrun <= 1'b0;
      sent_cnt <= 8'h00;
      wb_dat_o <= 32'h0000_0000;
      wb_ack_o <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      counts <= next_counts;
      chg_cnt <= next_chg_cnt;
      overrun <= next_overrun;
      sent_cnt <= next_sent_cnt;
      wb_dat_o <= next_dat;
      wb_ack_o <= next_ack;
    end
  end
  // Entry memory address: own entries first, other pipes after them
  assign mem_rd_addr = (state == inband_pkg::ST_OTH_RD) ?
                       idx + MEM_AW'(OWN_MAX) : idx;
  // Block sequencer and bit shifter
  always_comb begin
    next_state = state;
    next_ret = ret;
    next_sh = sh;
    next_cnt = cnt;
    next_idx = idx;
    next_bits_left = bits_left;
    next_acc = acc;
    next_nbits = nbits;
    next_pend = pend && !push_s.ready;
    next_pend_data = pend_data;
    nb_inc = nbits + 4'h1;
    acc_inc = {acc[6:0], sh[CW-1]};
    unique case (state)
      inband_pkg::ST_IDLE: begin
        // start on first frame of interleaving frame
        if (il_first_i && insert && !busy) begin
          next_sh = {inband_pkg::PAD_TYPE_A, chg_cnt, 8'h00,
                     {(CW-inband_pkg::COMMON_W){1'b0}}};
          next_cnt = 7'(inband_pkg::COMMON_W);
          next_bits_left = 16'(inband_pkg::COMMON_W + inband_pkg::TAIL_W)
                         + 16'(inband_pkg::OWN_ENTRY_W) * 16'(pi_eff)
                         + 16'(inband_pkg::OTHER_ENTRY_W) * 16'(ocnt_eff);
          next_idx = '0;
          next_ret = inband_pkg::ST_OWN_RD;
          next_state = inband_pkg::ST_SHIFT;
        end
      end
      inband_pkg::ST_SHIFT: begin
        // MSB first, one bit a cycle
        if (cnt == 7'h00) begin
          next_state = ret;
        end else if (!pend) begin
          next_sh = {sh[CW-2:0], 1'b0};
          next_cnt = cnt - 7'h01;
          next_bits_left = bits_left - 16'h0001;
          next_acc = acc_inc;
          next_nbits = nb_inc;
          if (nb_inc == 4'h8 || bits_left == 16'h0001) begin
            next_pend = 1'b1;
            next_pend_data = {bits_left == 16'h0001,
                              acc_inc << (4'h8 - nb_inc)};
            next_acc = 8'h00;
            next_nbits = 4'h0;
          end
        end
      end
      inband_pkg::ST_OWN_RD: begin
        // Wait for registered memory read
        next_state = inband_pkg::ST_OWN_LD;
      end
      inband_pkg::ST_OWN_LD: begin
        // own entry, reserved sent as zero
        next_sh = {mem_rd_data[inband_pkg::OWN_ENTRY_W-1:
                               inband_pkg::RSV2_W],
                   8'h00, {(CW-inband_pkg::OWN_ENTRY_W){1'b0}}};
        next_cnt = 7'(inband_pkg::OWN_ENTRY_W);
        next_idx = idx + 1'b1;
        next_ret = (8'(idx) + 8'h01 == pi_eff) ? inband_pkg::ST_TAIL
                                                : inband_pkg::ST_OWN_RD;
        next_state = inband_pkg::ST_SHIFT;
      end
      inband_pkg::ST_TAIL: begin
        next_sh = {counts[inband_pkg::COUNTS_NBLK_LSB +: 10], ocnt_eff,
                   {(CW-inband_pkg::TAIL_W){1'b0}}};
        next_cnt = 7'(inband_pkg::TAIL_W);
        next_idx = '0;
        next_ret = (ocnt_eff == 8'h00) ? inband_pkg::ST_IDLE
                                       : inband_pkg::ST_OTH_RD;
        next_state = inband_pkg::ST_SHIFT;
      end
      inband_pkg::ST_OTH_RD: begin
        // Wait for registered memory read
        next_state = inband_pkg::ST_OTH_LD;
      end
      inband_pkg::ST_OTH_LD: begin
        next_sh = {mem_rd_data[inband_pkg::OTHER_ENTRY_W-1:
                               inband_pkg::RSV3_W],
                   8'h00, {(CW-inband_pkg::OTHER_ENTRY_W){1'b0}}};
        next_cnt = 7'(inband_pkg::OTHER_ENTRY_W);
        next_idx = idx + 1'b1;
        // nothing after type A; no type B here
        next_ret = (8'(idx) + 8'h01 == ocnt_eff) ? inband_pkg::ST_IDLE
                                                  : inband_pkg::ST_OTH_RD;
        next_state = inband_pkg::ST_SHIFT;
      end
      default: next_state = inband_pkg::ST_IDLE;
    endcase
  end
  // Sequencer flops
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= inband_pkg::ST_IDLE;
      ret <= inband_pkg::ST_IDLE;
      sh <= '0;
      cnt <= 7'h00;
      idx <= '0;
      bits_left <= 16'h0000;
      acc <= 8'h00;
      nbits <= 4'h0;
      pend <= 1'b0;
      pend_data <= 9'h000;
    end else begin
      state <= next_state;
      ret <= next_ret;
      sh <= next_sh;
      cnt <= next_cnt;
      idx <= next_idx;
      bits_left <= next_bits_left;
      acc <= next_acc;
      nbits <= next_nbits;
      pend <= next_pend;
      pend_data <= next_pend_data;
    end
  end
  // Pending byte offered to the FIFO; full FIFO stalls the shifter
  assign push_s.valid = pend;
  assign push_s.data = pend_data;
  entry_mem #(.W(CW), .DEPTH(MEM_DEPTH), .AW(MEM_AW)) u_mem (
    .clk_i(clk_i),
    .wr_en_i(mem_we),
    .wr_addr_i(wb_adr_i[7:3]),
    .wr_mask_i(mem_mask),
    .wr_data_i({wb_dat_i, wb_dat_i}),
    .rd_addr_i(mem_rd_addr),
    .rd_data_o(mem_rd_data)
  );
  pad_fifo #(.W(9), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_s(push_s),
    .out_data_o({pad_last_o, pad_data_o}),
    .out_valid_o(pad_valid_o),
    .out_ready_i(pad_ready_i)
  );
endmodule : inband_dynamic_signalling_inserter

/* inband_pkg.sv */
// Constants, field layout and register map of the in-band signalling inserter
package inband_pkg;
  // Register byte offsets on the bus
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_COUNTS = 12'h004;
  localparam logic [11:0] ADDR_CHANGE = 12'h008;
  localparam logic [11:0] ADDR_STATUS = 12'h00c;
  localparam logic [11:0] ADDR_MEM_BASE = 12'h100;
  // Control register layout
  localparam int CTRL_MODE_B_BIT = 0;
  localparam int CTRL_FLAG_BIT = 1;
  localparam int CTRL_PI_LSB = 8;
  localparam int CTRL_IJ_LSB = 16;
  // Counts register layout
  localparam int COUNTS_OCNT_LSB = 0;
  localparam int COUNTS_NBLK_LSB = 8;
  // Change register layout
  localparam int CHANGE_ANNOUNCE_BIT = 0;
  localparam int CHANGE_AFFECTS_BIT = 1;
  // Status register layout
  localparam int STATUS_BUSY_BIT = 0;
  localparam int STATUS_OVERRUN_BIT = 1;
  localparam int STATUS_SENT_LSB = 8;
  // Field widths of the type A block
  localparam int PAD_TYPE_W = 2;
  localparam int CHG_W = 8;
  localparam int RSV1_W = 8;
  localparam int SPACING_W = 22;
  localparam int RF_W = 3;
  localparam int START_W = 22;
  localparam int RSV2_W = 8;
  localparam int NBLK_W = 10;
  localparam int OCNT_W = 8;
  localparam int PID_W = 8;
  localparam int RSV3_W = 8;
  // Padding type code of a type A block
  localparam logic [PAD_TYPE_W-1:0] PAD_TYPE_A = 2'h0;
  // Chunk lengths in bits
  localparam int COMMON_W = PAD_TYPE_W + CHG_W + RSV1_W;
  localparam int OWN_ENTRY_W = SPACING_W + RF_W + START_W + RSV2_W;
  localparam int TAIL_W = NBLK_W + OCNT_W;
  localparam int OTHER_ENTRY_W = PID_W + START_W + NBLK_W + RSV3_W;
  // Chunk shifter and entry memory word width
  localparam int CHUNK_W = 64;
  // Reset values
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] COUNTS_RESET = 32'h0000_0000;
  // Serializer states, one-hot
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_SHIFT = 7'h02,
    ST_OWN_RD = 7'h04,
    ST_OWN_LD = 7'h08,
    ST_TAIL = 7'h10,
    ST_OTH_RD = 7'h20,
    ST_OTH_LD = 7'h40
  } ser_state_t;
endpackage : inband_pkg

/* byte_stream_if.sv */
// Valid/ready carrier between the serializer and the output FIFO
`timescale 1ns/1ps
interface byte_stream_if #(parameter int W = 9);
  logic valid; // Word offered
  logic ready; // Word accepted
  logic [W-1:0] data; // Offered word
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : byte_stream_if

/* entry_mem.sv */
// Entry memory for per-frame dynamic parameters, registered read
`timescale 1ns/1ps
module entry_mem #(
  parameter int W = 64,
  parameter int DEPTH = 32,
  parameter int AW = 5
) (
  input wire logic clk_i,
  input wire logic wr_en_i,
  input wire logic [AW-1:0] wr_addr_i,
  input wire logic [W-1:0] wr_mask_i,
  input wire logic [W-1:0] wr_data_i,
  input wire logic [AW-1:0] rd_addr_i,
  output logic [W-1:0] rd_data_o
);
  logic [W-1:0] mem [DEPTH]; // Storage, no reset needed
  logic [W-1:0] next_word; // Merged write word

  // Merge masked write into the old word
  always_comb begin
    next_word = (mem[wr_addr_i] & ~wr_mask_i) | (wr_data_i & wr_mask_i);
  end

  // Write port and registered read port
  always_ff @(posedge clk_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= next_word;
    end
    rd_data_o <= mem[rd_addr_i];
  end
endmodule : entry_mem

/* pad_fifo.sv */
// Output FIFO with registered output stage
`timescale 1ns/1ps
module pad_fifo #(
  parameter int W = 9,
  parameter int DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  byte_stream_if.snk in_s,
  output logic [W-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] store [DEPTH]; // Word storage
  logic [AW-1:0] wr_ptr, next_wr_ptr; // Write pointer
  logic [AW-1:0] rd_ptr, next_rd_ptr; // Read pointer
  logic [AW:0] count, next_count; // Stored words, output stage excluded
  logic next_out_valid; // Output stage valid
  logic [W-1:0] next_out_data; // Output stage word
  logic push; // Word taken in
  logic pop; // Word moved to output stage

  // Full only when every slot holds a word
  assign in_s.ready = (count != (AW+1)'(DEPTH));

  // Pointer, count and output stage update
  always_comb begin
    push = in_s.valid && in_s.ready;
    pop = (count != '0) && (!out_valid_o || out_ready_i);
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    next_count = count + (AW+1)'(push) - (AW+1)'(pop);
    next_out_data = pop ? store[rd_ptr] : out_data_o;
    if (pop) begin
      next_out_valid = 1'b1;
    end else if (out_ready_i) begin
      next_out_valid = 1'b0;
    end else begin
      next_out_valid = out_valid_o;
    end
  end

  // Register state, storage written on push
  always_ff @(posedge clk_i) begin
    if (push) begin
      store[wr_ptr] <= in_s.data;
    end
    if (rst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      out_valid_o <= 1'b0;
      out_data_o <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
      out_valid_o <= next_out_valid;
      out_data_o <= next_out_data;
    end
  end
endmodule : pad_fifo

/* inband_assertions.sv */
// Port checks of the in-band signalling inserter
`timescale 1ns/1ps
module inband_assertions (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic [7:0] pad_data_o,
  input wire logic pad_last_o,
  input wire logic pad_valid_o,
  input wire logic pad_ready_i
);
  logic [7:0] idx; // Byte index inside the block
  logic [7:0] next_idx; // Index after this edge
  // Count taken bytes, back to zero after the last one
  always_comb begin
    next_idx = idx;
    if (pad_valid_o && pad_ready_i) begin
      next_idx = pad_last_o ? 8'h00 : idx + 8'h01;
    end
  end
  // Register only; cleared so a reset mid-block restarts framing
  always_ff @(posedge clk_i) begin
    idx <= rst_i ? 8'h00 : next_idx;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_held;
    pad_valid_o && !pad_ready_i;
  endsequence
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_answer: assert property (s_req |=> wb_ack_o)
    else $error("no ack one cycle after request");
  a_ack_unasked: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  a_byte_held: assert property (s_held |=> pad_valid_o &&
    $stable(pad_data_o) && $stable(pad_last_o))
    else $error("byte changed before it was taken");
  a_type_first: assert property (
    pad_valid_o && idx == 8'h00 |->
    pad_data_o[7:6] == inband_pkg::PAD_TYPE_A)
    else $error("block does not start with type A code");
  a_rsv_byte1: assert property (
    pad_valid_o && idx == 8'h01 |-> pad_data_o[5:0] == 6'h00)
    else $error("reserved bits in second byte not zero");
  a_rsv_byte2: assert property (
    pad_valid_o && idx == 8'h02 |-> pad_data_o[7:6] == 2'h0)
    else $error("reserved bits in third byte not zero");
  a_last_late: assert property (
    pad_valid_o && pad_last_o |-> idx >= 8'h0b)
    else $error("block shorter than one own entry");
endmodule : inband_assertions

/* pad_rx_model.sv */
// Receiver model that takes padding bytes
`timescale 1ns/1ps
module pad_rx_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] data_i,
  input wire logic last_i,
  input wire logic valid_i,
  input wire logic stall_i,
  output logic ready_o
);
  logic [7:0] got[$]; // Bytes taken, cleared by the bench
  int blocks = 0; // Whole blocks taken
  logic [1:0] cnt = 2'h0; // Pacing, refuses one cycle in four
  initial ready_o = 1'b0;
  // Trailing bits stored raw, never decoded
  always @(posedge clk_i) begin
    cnt <= cnt + 2'h1;
    ready_o <= !rst_i && !stall_i && cnt != 2'h3;
    if (!rst_i && valid_i && ready_o) begin
      got.push_back(data_i);
      if (last_i) blocks++;
    end
  end
endmodule : pad_rx_model

/* tb_inband_dynamic_signalling_inserter.sv */
// Testbench of the in-band signalling inserter
`timescale 1ns/1ps
module tb_inband_dynamic_signalling_inserter;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0;
  logic il = 1'b0, stall = 1'b0, ack, vld, lst, rdy;
  logic [11:0] adr = 12'h000;
  logic [31:0] wdat = 32'h0, rdat, dat_o;
  logic [7:0] pd;
  logic [63:0] w;
  int fails = 0, cmp_count = 0;
  bit q[$]; // Expected bit stream
  typedef struct {
    logic [31:0] c;
    logic [31:0] n;
    int p;
    int o;
    bit ins;
  } row_t;
  // Control, counts, own entries, other entries, block expected
  row_t rows[6] = '{
    '{32'h0001_0102, 32'h0000_6402, 1, 0, 0},
    '{32'h0001_0201, 32'h0000_6400, 2, 0, 0},
    '{32'h0001_0101, 32'h0000_6400, 1, 0, 1},
    '{32'h0002_0303, 32'h0000_6402, 3, 0, 1},
    '{32'h0001_0103, 32'h0000_6402, 1, 2, 1},
    '{32'h0001_0003, 32'h0000_6400, 1, 0, 1}};
  logic [11:0] ra[6] = '{inband_pkg::ADDR_CTRL, inband_pkg::ADDR_COUNTS,
    inband_pkg::ADDR_CHANGE, inband_pkg::ADDR_STATUS, 12'h010,
    inband_pkg::ADDR_MEM_BASE};
  // Free-running 25 MHz clock
  always #20 clk_i = ~clk_i;
  inband_dynamic_signalling_inserter #(.FIFO_DEPTH(16)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .il_first_i(il),
    .pad_data_o(pd), .pad_last_o(lst), .pad_valid_o(vld),
    .pad_ready_i(rdy));
  pad_rx_model rx (.clk_i(clk_i), .rst_i(rst_i), .data_i(pd),
    .last_i(lst), .valid_i(vld), .stall_i(stall), .ready_o(rdy));
  // Entry word; nonzero low byte shows reserved bits forced to zero
  function automatic logic [63:0] ent(input int k);
    return {32'h5a3c_96e1 + 32'(k), 32'hc3a5_0ff0 ^ {4{8'(k)}}};
  endfunction : ent
  task automatic results();
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : results
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Classic cycle: hold until ack is sampled, then release
  task automatic wb(input logic wr, input logic [11:0] a,
                    input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= wr;
    adr <= a;
    wdat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    rdat = dat_o;
    cyc <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  task automatic put(input logic [63:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) q.push_back(v[i]);
  endtask : put
  // Expected block, change counter 1 and block count 0x64
  task automatic build(input int p, input int o);
    q.delete();
    put(64'h0, 2);
    put(64'h1, 8);
    put(64'h0, 8);
    for (int j = 0; j < p; j++) begin
      w = ent(j);
      put({w[54:8], 8'h00}, 55);
    end
    put(64'h064, 10);
    put(64'(o), 8);
    for (int i = 0; i < o; i++) begin
      w = ent(3 + i);
      put({w[47:8], 8'h00}, 48);
    end
    while (q.size() % 8 != 0) q.push_back(1'b0);
  endtask : build
  task automatic pulse();
    @(posedge clk_i);
    il <= 1'b1;
    @(posedge clk_i);
    il <= 1'b0;
  endtask : pulse
  // One trigger; optional second one while stalled
  task automatic fire(input bit ins, input bit ovr);
    int t, b;
    logic [7:0] e;
    b = rx.blocks;
    rx.got.delete();
    pulse();
    if (ovr) begin
      repeat (300) @(posedge clk_i);
      pulse();
      wb(1'b0, inband_pkg::ADDR_STATUS, 32'h0);
      chk("busy_overrun", 32'h3, rdat & 32'h3);
      stall <= 1'b0;
    end
    t = 0;
    while (rx.blocks == b && t < (ins ? 3000 : 300)) begin
      @(posedge clk_i);
      t++;
    end
    chk("byte_count", ins ? q.size() / 8 : 0, rx.got.size());
    for (int k = 0; ins && k < q.size() / 8 && k < rx.got.size(); k++) begin
      for (int i = 0; i < 8; i++) e[7 - i] = q[8 * k + i];
      chk("block_byte", {24'h0, e}, {24'h0, rx.got[k]});
    end
  endtask : fire
  // Run limit well above the longest expected sequence
  initial begin
    #2000000;
    fails++;
    results();
  end
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b1, 12'h010, 32'h0000_ffff);
    foreach (ra[k]) begin
      wb(1'b0, ra[k], 32'h0);
      chk("reset_or_unmapped", 32'h0, rdat);
    end
    for (int k = 1; k < 4; k++) wb(1'b1, inband_pkg::ADDR_CHANGE, 32'(k));
    wb(1'b0, inband_pkg::ADDR_CHANGE, 32'h0);
    chk("change_count", 32'h1, rdat & 32'hff);
    for (int k = 0; k < 5; k++) begin
      w = ent(k);
      wb(1'b1, inband_pkg::ADDR_MEM_BASE + 12'(8 * (k < 3 ? k : k + 5)),
         w[31:0]);
      wb(1'b1, inband_pkg::ADDR_MEM_BASE + 12'(8 * (k < 3 ? k : k + 5) + 4),
         w[63:32]);
    end
    foreach (rows[r]) begin
      wb(1'b1, inband_pkg::ADDR_CTRL, rows[r].c);
      wb(1'b1, inband_pkg::ADDR_COUNTS, rows[r].n);
      build(rows[r].p, rows[r].o);
      fire(rows[r].ins, 1'b0);
    end
    // Far side stalls: FIFO fills, second trigger is refused
    wb(1'b1, inband_pkg::ADDR_CTRL, 32'h0001_0103);
    wb(1'b1, inband_pkg::ADDR_COUNTS, 32'h0000_6402);
    build(1, 2);
    stall <= 1'b1;
    fire(1'b1, 1'b1);
    wb(1'b1, inband_pkg::ADDR_STATUS, 32'h2);
    wb(1'b0, inband_pkg::ADDR_STATUS, 32'h0);
    chk("status", 32'h0000_0500, rdat);
    results();
  end
endmodule : tb_inband_dynamic_signalling_inserter
bind inband_dynamic_signalling_inserter inband_assertions chk_u (
  .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .pad_data_o,
  .pad_last_o, .pad_valid_o, .pad_ready_i);
